/* File: inc/otpc_pkg.sv */
package otpc_pkg;
    localparam logic [6:0] ADDR_PIN_HIGH   = 7'h73;
    localparam logic [6:0] ADDR_PIN_LOW    = 7'h75;
    localparam logic [6:0] ADDR_PIN_OPEN   = 7'h79;

    localparam logic [6:0] REG_WP_KEY      = 7'h09;
    localparam logic [6:0] REG_REG_CTRL    = 7'h4B;
    localparam logic [6:0] REG_BANK_SEL    = 7'h7F;

    localparam logic [7:0] BANK_ZERO       = 8'h00;
    localparam logic [7:0] WP_UNLOCK_KEY   = 8'h5A;
    localparam logic [7:0] WP_LOCK_KEY     = 8'h00;
    localparam logic [7:0] REG_CTRL_LV     = 8'h04;

    localparam logic [7:0] BANK_RST        = 8'h00;
    localparam logic [7:0] WP_KEY_RST      = 8'h00;
    localparam logic [7:0] REG_CTRL_RST    = 8'h00;
    localparam int         REG_OFF_BIT     = 2;

    localparam int         DIR_BIT         = 7;
    localparam logic [2:0] LAST_BIT        = 3'h7;
    localparam logic [1:0] STRAP_WAIT      = 2'h3;

    typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA} otpc_phase_t;
endpackage

/* File: rtl/otpc_sync.sv */
`timescale 1ns/1ps
module otpc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule

/* File: rtl/otpc_top.sv */
// Operation
// [R01] On the two-wire variant the 7-bit bus address is 0x73 with the select pin high, 0x75 low, 0x79 open.
// [R02] The motion output is active low and rests high when no motion is reported.
// [R03] The chip select is active low and the serial port answers only while it is low.
// [R04] The host should wait 10 ms after the core supply is stable before any serial access.
// [R05] After power-up the registers select the high-voltage supply with the regulator on.
// [R06] For the low-voltage supply the host loads 0x04 into register 0x4B after power-up.
// [R07] Writing 0x00 to register 0x7F selects register bank 0.
// [R08] Writing 0x5A to register 0x09 lifts write protection and writing 0x00 there restores it.
// [R09] The host selects bank 0, unlocks, programs the regulator register, then relocks, in that order.
// [R10] While protection is engaged, writes to the regulator control register are ignored.
`timescale 1ns/1ps
module otpc_top
    import otpc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       chipSelectN,
    input  wire logic       spiSclk,
    input  wire logic       sdioIn,
    output logic            sdioOut,
    output logic            sdioOe,
    input  wire logic       addressSelectPin,
    input  wire logic       addressSelectDriven,
    output logic      [6:0] slaveAddr,
    output logic            slaveAddrValid,
    input  wire logic       motionReport,
    output logic            motionN,
    output logic            regulatorOn,
    output logic      [7:0] bankSel
);
    import otpc_pkg::*;

    logic [4:0] syncOut;
    logic       sclkS;
    logic       ncsS;
    logic       sdioS;
    logic       selS;
    logic       drvS;

    // sclk and chip select pass inverted so the synchroniser reset equals their idle-high level
    otpc_sync #(.W(5)) uSync (
        .clk  (clk),
        .rstn (rstn),
        .din  ({~spiSclk, ~chipSelectN, sdioIn, addressSelectPin, addressSelectDriven}),
        .dout (syncOut)
    );

    assign sclkS                = ~syncOut[4];
    assign ncsS                 = ~syncOut[3];
    assign {sdioS, selS, drvS}  = syncOut[2:0];

    // serial engine state
    otpc_phase_t phase_ff,   nxt_phase;
    logic        sclkPrev_ff;
    logic [2:0]  bitCnt_ff,  nxt_bitCnt;
    logic [7:0]  shIn_ff,    nxt_shIn;
    logic [7:0]  shOut_ff,   nxt_shOut;
    logic [6:0]  addr_ff,    nxt_addr;
    logic        isWrite_ff, nxt_isWrite;
    logic        oe_ff,      nxt_oe;
    logic        outBit_ff,  nxt_outBit;
    logic        sclkRise;
    logic        sclkFall;
    logic [7:0]  byteIn;
    logic        wrEn;

    // register file state
    logic [7:0]  bank_ff,    nxt_bank;
    logic [7:0]  wpKey_ff,   nxt_wpKey;
    logic [7:0]  regCtrl_ff, nxt_regCtrl;
    logic        regWritten_ff, nxt_regWritten;

    // strap and motion state
    logic [1:0]  strapCnt_ff, nxt_strapCnt;
    logic [6:0]  slaveAddr_ff, nxt_slaveAddr;
    logic        addrValid_ff, nxt_addrValid;
    logic        motionN_ff,   nxt_motionN;

    assign sclkRise = sclkS & ~sclkPrev_ff;
    assign sclkFall = ~sclkS & sclkPrev_ff;
    assign byteIn   = {shIn_ff[6:0], sdioS};

    function automatic logic [7:0] readMux(input logic [6:0] a, input logic [7:0] bank,
                                           input logic [7:0] wp, input logic [7:0] rc);
        logic [7:0] v;
        v = 8'h00;
        if (a == REG_BANK_SEL) begin
            v = bank;
        end else if (bank == BANK_ZERO && a == REG_WP_KEY) begin
            v = wp;
        end else if (bank == BANK_ZERO && a == REG_REG_CTRL) begin
            v = rc;
        end
        return v;
    endfunction

    always_comb begin
        nxt_phase   = phase_ff;
        nxt_bitCnt  = bitCnt_ff;
        nxt_shIn    = shIn_ff;
        nxt_shOut   = shOut_ff;
        nxt_addr    = addr_ff;
        nxt_isWrite = isWrite_ff;
        nxt_oe      = oe_ff;
        nxt_outBit  = outBit_ff;
        wrEn        = 1'b0;
        if (ncsS) begin
            // deselected: port idles and the pad is released
            nxt_phase  = PH_IDLE; // [R03]
            nxt_bitCnt = 3'h0;
            nxt_oe     = 1'b0; // [R03]
        end else begin
            case (phase_ff)
                PH_IDLE: begin
                    nxt_phase  = PH_ADDR;
                    nxt_bitCnt = 3'h0;
                end
                PH_ADDR: begin
                    if (sclkFall) begin
                        nxt_oe = 1'b0;
                    end
                    if (sclkRise) begin
                        nxt_shIn   = byteIn;
                        nxt_bitCnt = bitCnt_ff + 3'h1;
                        if (bitCnt_ff == LAST_BIT) begin
                            nxt_isWrite = byteIn[DIR_BIT];
                            nxt_addr    = byteIn[6:0];
                            nxt_shOut   = readMux(byteIn[6:0], bank_ff, wpKey_ff, regCtrl_ff);
                            nxt_phase   = PH_DATA;
                        end
                    end
                end
                PH_DATA: begin
                    if (sclkFall && !isWrite_ff) begin
                        nxt_oe     = 1'b1;
                        nxt_outBit = shOut_ff[7];
                        nxt_shOut  = {shOut_ff[6:0], 1'b0};
                    end
                    if (sclkRise) begin
                        nxt_shIn   = byteIn;
                        nxt_bitCnt = bitCnt_ff + 3'h1;
                        if (bitCnt_ff == LAST_BIT) begin
                            wrEn      = isWrite_ff;
                            nxt_phase = PH_ADDR;
                        end
                    end
                end
                default: begin
                    nxt_phase = PH_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        nxt_bank       = bank_ff;
        nxt_wpKey      = wpKey_ff;
        nxt_regCtrl    = regCtrl_ff;
        nxt_regWritten = regWritten_ff;
        if (wrEn) begin
            if (addr_ff == REG_BANK_SEL) begin
                nxt_bank = byteIn; // [R07]
            end else if (bank_ff == BANK_ZERO) begin
                if (addr_ff == REG_WP_KEY) begin
                    nxt_wpKey = byteIn; // [R08]
                end
                if (addr_ff == REG_REG_CTRL && wpKey_ff == WP_UNLOCK_KEY) begin
                    nxt_regCtrl    = byteIn; // [R10]
                    nxt_regWritten = 1'b1;
                end
            end
        end
    end

    always_comb begin
        nxt_strapCnt  = strapCnt_ff;
        nxt_slaveAddr = slaveAddr_ff;
        nxt_addrValid = addrValid_ff;
        if (strapCnt_ff != STRAP_WAIT) begin
            nxt_strapCnt = strapCnt_ff + 2'h1;
        end else if (!addrValid_ff) begin
            nxt_addrValid = 1'b1;
            if (!drvS) begin
                nxt_slaveAddr = ADDR_PIN_OPEN; // [R01]
            end else if (selS) begin
                nxt_slaveAddr = ADDR_PIN_HIGH; // [R01]
            end else begin
                nxt_slaveAddr = ADDR_PIN_LOW; // [R01]
            end
        end
        nxt_motionN = ~motionReport; // [R02]
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_ff      <= PH_IDLE;
            sclkPrev_ff   <= 1'b1;
            bitCnt_ff     <= 3'h0;
            shIn_ff       <= 8'h00;
            shOut_ff      <= 8'h00;
            addr_ff       <= 7'h00;
            isWrite_ff    <= 1'b0;
            oe_ff         <= 1'b0;
            outBit_ff     <= 1'b0;
            bank_ff       <= BANK_RST;
            wpKey_ff      <= WP_KEY_RST;
            regCtrl_ff    <= REG_CTRL_RST; // [R05]
            regWritten_ff <= 1'b0;
            strapCnt_ff   <= 2'h0;
            slaveAddr_ff  <= ADDR_PIN_OPEN;
            addrValid_ff  <= 1'b0;
            motionN_ff    <= 1'b1; // [R02]
        end else begin
            phase_ff      <= nxt_phase;
            sclkPrev_ff   <= sclkS;
            bitCnt_ff     <= nxt_bitCnt;
            shIn_ff       <= nxt_shIn;
            shOut_ff      <= nxt_shOut;
            addr_ff       <= nxt_addr;
            isWrite_ff    <= nxt_isWrite;
            oe_ff         <= nxt_oe;
            outBit_ff     <= nxt_outBit;
            bank_ff       <= nxt_bank;
            wpKey_ff      <= nxt_wpKey;
            regCtrl_ff    <= nxt_regCtrl;
            regWritten_ff <= nxt_regWritten;
            strapCnt_ff   <= nxt_strapCnt;
            slaveAddr_ff  <= nxt_slaveAddr;
            addrValid_ff  <= nxt_addrValid;
            motionN_ff    <= nxt_motionN;
        end
    end

    assign sdioOut        = outBit_ff;
    assign sdioOe         = oe_ff;
    assign slaveAddr      = slaveAddr_ff;
    assign slaveAddrValid = addrValid_ff;
    assign motionN        = motionN_ff;
    assign regulatorOn    = ~regCtrl_ff[REG_OFF_BIT]; // [R05]
    assign bankSel        = bank_ff;

    strap_addr_a: assert property (@(posedge clk) disable iff (!rstn) // [R01]
        $rose(addrValid_ff) |-> ((slaveAddr_ff == ADDR_PIN_OPEN) == !$past(drvS))
            && (!$past(drvS) || slaveAddr_ff == ($past(selS) ? ADDR_PIN_HIGH : ADDR_PIN_LOW)))
        else $error("bus address does not follow the select pin");

    motion_level_a: assert property (@(posedge clk) disable iff (!rstn) // [R02]
        ##1 (motionN == !$past(motionReport)))
        else $error("motion output is not the active-low report");

    cs_release_a: assert property (@(posedge clk) disable iff (!rstn) // [R03]
        ncsS |=> (!sdioOe && phase_ff == PH_IDLE))
        else $error("port still active while deselected");

    reg_default_a: assert property (@(posedge clk) disable iff (!rstn) // [R05]
        !regWritten_ff |-> (regulatorOn && regCtrl_ff == REG_CTRL_RST))
        else $error("regulator left default without a write");

    bank_write_a: assert property (@(posedge clk) disable iff (!rstn) // [R07]
        (wrEn && addr_ff == REG_BANK_SEL) |=> (bank_ff == $past(byteIn)))
        else $error("bank select write not taken");

    key_unlock_a: assert property (@(posedge clk) disable iff (!rstn) // [R08]
        (wrEn && bank_ff == BANK_ZERO && addr_ff == REG_WP_KEY)
            |=> ((wpKey_ff == WP_UNLOCK_KEY) == ($past(byteIn) == WP_UNLOCK_KEY)))
        else $error("write protect key not updated");

    protect_hold_a: assert property (@(posedge clk) disable iff (!rstn) // [R10]
        (wpKey_ff != WP_UNLOCK_KEY) |=> $stable(regCtrl_ff))
        else $error("regulator control changed while protected");
endmodule

/* File: dv/otpc_host.sv */
`timescale 1ns/1ps
module otpc_host (
    input  wire logic clk,
    output logic      chipSelectN,
    output logic      spiSclk,
    output logic      sdioIn,
    input  wire logic sdioOut,
    input  wire logic sdioOe
);
    logic hostBit;
    logic hostOe;

    // released line shows the inverse of the last host bit, not a held value
    assign sdioIn = sdioOe ? sdioOut : (hostOe ? hostBit : ~hostBit);

    initial begin
        chipSelectN = 1'b1;
        spiSclk     = 1'b1;
        hostBit     = 1'b0;
        hostOe      = 1'b0;
    end

    task automatic phase();
        repeat (6) @(negedge clk);
    endtask

    // one address/data pair in mode 3; sel low leaves the device deselected
    task automatic xfer(input logic sel, input logic [7:0] addr, input logic [7:0] wdat,
                        output logic [7:0] rdat, output logic oeAll);
        oeAll = 1'b1;
        rdat  = 8'h00;
        @(negedge clk);
        chipSelectN = ~sel;
        phase();
        for (int i = 15; i >= 0; i--) begin
            spiSclk = 1'b0;
            hostOe  = (i > 7) || addr[7];
            if (hostOe) begin
                hostBit = (i > 7) ? addr[i-8] : wdat[i];
            end
            phase();
            if (i <= 7) begin
                rdat[i] = sdioOut;
                oeAll   = oeAll & sdioOe;
            end
            spiSclk = 1'b1;
            phase();
        end
        hostOe      = 1'b0;
        chipSelectN = 1'b1;
        phase();
    endtask
endmodule

/* File: dv/optical_tracker_power_config_tb_top.sv */
`timescale 1ns/1ps
module optical_tracker_power_config_tb_top;
    import otpc_pkg::*;
    logic       clk, rstn, addressSelectPin, addressSelectDriven, motionReport;
    logic       chipSelectN, spiSclk, sdioIn, sdioOut, sdioOe;
    logic       slaveAddrValid, motionN, regulatorOn, oe;
    logic [6:0] slaveAddr;
    logic [7:0] bankSel, rd;
    int         mismatches, compares, cycles;

    otpc_top DUT (
        .clk                 (clk),
        .rstn                (rstn),
        .chipSelectN         (chipSelectN),
        .spiSclk             (spiSclk),
        .sdioIn              (sdioIn),
        .sdioOut             (sdioOut),
        .sdioOe              (sdioOe),
        .addressSelectPin    (addressSelectPin),
        .addressSelectDriven (addressSelectDriven),
        .slaveAddr           (slaveAddr),
        .slaveAddrValid      (slaveAddrValid),
        .motionReport        (motionReport),
        .motionN             (motionN),
        .regulatorOn         (regulatorOn),
        .bankSel             (bankSel)
    );

    otpc_host HOST (
        .clk         (clk),
        .chipSelectN (chipSelectN),
        .spiSclk     (spiSclk),
        .sdioIn      (sdioIn),
        .sdioOut     (sdioOut),
        .sdioOe      (sdioOe)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic close_out();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        HOST.xfer(1'b1, {1'b1, a}, d, rd, oe);
    endtask

    task automatic rdReg(input logic [6:0] a, input logic [7:0] exp);
        HOST.xfer(1'b1, {1'b0, a}, 8'h00, rd, oe);
        chk(rd, exp);
        chk({7'h00, oe}, 8'h01);
    endtask

    task automatic doReset(input logic pin, input logic drv);
        @(negedge clk);
        addressSelectPin    = pin;
        addressSelectDriven = drv;
        rstn                = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        // start-up wait before serial access, scaled down to 8 cycles to cover the sync and strap latch
        repeat (8) @(negedge clk);
    endtask

    task automatic test_strap();
        for (int k = 0; k < 3; k++) begin
            doReset(k == 0, k < 2);
            chk({1'b0, slaveAddr}, {1'b0, (k == 0) ? ADDR_PIN_HIGH :
                (k == 1) ? ADDR_PIN_LOW : ADDR_PIN_OPEN});
            chk({7'h00, slaveAddrValid}, 8'h01);
        end
    endtask

    task automatic test_defaults();
        chk({7'h00, motionN}, 8'h01);
        chk({7'h00, regulatorOn}, 8'h01);
        chk(bankSel, BANK_RST);
        rdReg(REG_REG_CTRL, REG_CTRL_RST);
    endtask

    task automatic test_motion();
        @(negedge clk);
        motionReport = 1'b1;
        @(negedge clk);
        chk({7'h00, motionN}, 8'h00);
        motionReport = 1'b0;
        @(negedge clk);
        chk({7'h00, motionN}, 8'h01);
    endtask

    task automatic test_locked();
        wr(REG_REG_CTRL, REG_CTRL_LV);
        chk({7'h00, regulatorOn}, 8'h01);
        rdReg(REG_REG_CTRL, REG_CTRL_RST);
    endtask

    task automatic test_lowvolt();
        wr(REG_BANK_SEL, BANK_ZERO);
        wr(REG_WP_KEY, WP_UNLOCK_KEY);
        rdReg(REG_WP_KEY, WP_UNLOCK_KEY);
        wr(REG_REG_CTRL, REG_CTRL_LV);
        chk({7'h00, regulatorOn}, 8'h00);
        rdReg(REG_REG_CTRL, REG_CTRL_LV);
        wr(REG_WP_KEY, WP_LOCK_KEY);
        wr(REG_REG_CTRL, 8'h00);
        chk({7'h00, regulatorOn}, 8'h00);
    endtask

    task automatic test_bank();
        wr(REG_BANK_SEL, 8'h01);
        chk(bankSel, 8'h01);
        rdReg(REG_REG_CTRL, 8'h00);
        wr(REG_BANK_SEL, BANK_ZERO);
        chk(bankSel, BANK_ZERO);
        rdReg(REG_REG_CTRL, REG_CTRL_LV);
    endtask

    task automatic test_deselect();
        HOST.xfer(1'b0, {1'b1, REG_BANK_SEL}, 8'h05, rd, oe);
        chk(bankSel, BANK_ZERO);
        HOST.xfer(1'b0, {1'b0, REG_REG_CTRL}, 8'h00, rd, oe);
        chk({7'h00, oe}, 8'h00);
    endtask

    initial begin
        rstn                = 1'b0;
        addressSelectPin    = 1'b0;
        addressSelectDriven = 1'b0;
        motionReport        = 1'b0;
        mismatches          = 0;
        compares            = 0;
        cycles              = 0;
        test_strap();
        test_defaults();
        test_motion();
        test_locked();
        test_lowvolt();
        test_bank();
        test_deselect();
        close_out();
    end
endmodule
